//--- rtl/rvc_cfg_regs.v
// Rail voltage code and overcurrent configuration register bank
// Contract
// - Rail3 full ratio: code 0 is 0.3 V, code b4h is 2.1 V.
// - Rail3 half ratio: code 0 is 0.3 V, code 9eh is 3.46 V.
// - Rail4 full ratio: code 0 is 0.3 V, code b4h is 2.1 V.
// - Rail4 half ratio: 0.3 V, then 0.32 V, up to 3.46 V at 9eh.
// - Rail5 full ratio: 0.3 V, 0.31 V, up to 2.1 V at b4h.
// - Rail5 half ratio: 0.3 V, 0.32 V, up to 3.46 V at 9eh.
// - LDO code sits in bits 5:0, 0.6 to 2.65 V; bits 7:6 reserved.
// - LDO code 06h is 0.6 V, 07h 0.65 V, 2fh is 2.65 V.
// - Rail1 limit bits 7:6 select 7.5, 8, 8.5 or 9 A.
// - Rail2 bits 4:3 and rail3 bits 1:0 select 2.5 to 4 A.
// - Trip-disable bit 0 trips after 16 overcurrent cycles; 1 disables protection.
// - Five byte registers at 58h..5ch, all readable and writable by host.
`timescale 1ns/1ns
`include "rvc_map.vh"
module rvc_cfg_regs #(
    parameter TRIP_CYCLES = `RVC_OC_TRIP_CYCLES
) (
    input wire sys_clk,
    input wire arst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire third_buck_feedback_scale,
    input wire fourth_buck_feedback_scale,
    input wire fifth_buck_feedback_scale,
    input wire [2:0] sw_cycle,
    input wire [2:0] oc_detect,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg reg_addr_err,
    output reg [7:0] third_buck_target_code,
    output reg [7:0] fourth_buck_target_code,
    output reg [7:0] fifth_buck_target_code,
    output reg [5:0] linear_regulator_target_code,
    output reg [1:0] first_buck_current_limit,
    output reg [1:0] second_buck_current_limit,
    output reg [1:0] third_buck_current_limit,
    output reg first_buck_overcurrent_trip_en,
    output reg second_buck_overcurrent_trip_en,
    output reg [1:0] oc_fault,
    output reg [2:0] vcode_over_range
);
    reg [7:0] rail3_voltage_code_reg;
    reg [7:0] rail4_voltage_code_reg;
    reg [7:0] rail5_voltage_code_reg;
    reg [7:0] linear_regulator_voltage_code_reg;
    reg [7:0] current_limit_cfg_low_reg;
    reg [7:0] rdata_next;
    reg hit;
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg [2:0] sync3_reg;
    reg [2:0] oc_sync1_reg;
    reg [2:0] oc_sync2_reg;
    reg [2:0] oc_sync3_reg;
    reg [2:0] cyc_state_reg;
    reg [2:0] oc_state_reg;
    reg [4:0] cnt_reg [0:1];
    wire [1:0] trip_dis;
    wire [2:0] cyc_change;
    wire [2:0] cyc_rise;
    integer i;

    // Counter is five bits wide, so the trip level must stay below 32
    localparam [4:0] TRIP_FULL = TRIP_CYCLES[4:0];
    localparam [4:0] TRIP_LAST = TRIP_FULL - 5'h01;

    assign trip_dis = {current_limit_cfg_low_reg[`RVC_F_TRIP2_DIS],
                       current_limit_cfg_low_reg[`RVC_F_TRIP1_DIS]};
    // A change is taken only once stages two and three agree
    assign cyc_change = ~(sync2_reg ^ sync3_reg);
    assign cyc_rise = cyc_change & sync3_reg & ~cyc_state_reg;

    always @* begin
        hit = 1'b1;
        case (reg_addr)
            `RVC_ADDR_RAIL3_VCODE: rdata_next = rail3_voltage_code_reg;
            `RVC_ADDR_RAIL4_VCODE: rdata_next = rail4_voltage_code_reg;
            `RVC_ADDR_RAIL5_VCODE: rdata_next = rail5_voltage_code_reg;
            // Reserved LDO bits read back as zero
            `RVC_ADDR_LDO_VCODE: rdata_next = linear_regulator_voltage_code_reg;
            `RVC_ADDR_OC_CFG_LOW: rdata_next = current_limit_cfg_low_reg;
            default: begin
                rdata_next = 8'h00;
                hit = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rail3_voltage_code_reg <= `RVC_RST_VCODE;
            rail4_voltage_code_reg <= `RVC_RST_VCODE;
            rail5_voltage_code_reg <= `RVC_RST_VCODE;
            linear_regulator_voltage_code_reg <= `RVC_RST_LDO_VCODE;
            current_limit_cfg_low_reg <= `RVC_RST_OC_CFG;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            reg_addr_err <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_addr_err <= (reg_rd | reg_wr) & ~hit;
            // A read beside a write in one cycle returns the byte held before the write
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
            if (reg_wr) begin
                case (reg_addr)
                    `RVC_ADDR_RAIL3_VCODE: rail3_voltage_code_reg <= reg_wdata;
                    `RVC_ADDR_RAIL4_VCODE: rail4_voltage_code_reg <= reg_wdata;
                    `RVC_ADDR_RAIL5_VCODE: rail5_voltage_code_reg <= reg_wdata;
                    `RVC_ADDR_LDO_VCODE: begin
                        linear_regulator_voltage_code_reg <= reg_wdata & `RVC_LDO_CODE_MASK;
                    end
                    `RVC_ADDR_OC_CFG_LOW: current_limit_cfg_low_reg <= reg_wdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Field outputs; the analog ladder interprets the codes, the scale bit picks its range
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            third_buck_target_code <= `RVC_RST_VCODE;
            fourth_buck_target_code <= `RVC_RST_VCODE;
            fifth_buck_target_code <= `RVC_RST_VCODE;
            linear_regulator_target_code <= `RVC_LDO_MIN;
            // Configuration byte resets to zero, which leaves both trips armed
            first_buck_current_limit <= 2'h0;
            second_buck_current_limit <= 2'h0;
            third_buck_current_limit <= 2'h0;
            first_buck_overcurrent_trip_en <= 1'b1;
            second_buck_overcurrent_trip_en <= 1'b1;
            vcode_over_range <= 3'h0;
        end else begin
            third_buck_target_code <= rail3_voltage_code_reg;
            fourth_buck_target_code <= rail4_voltage_code_reg;
            fifth_buck_target_code <= rail5_voltage_code_reg;
            linear_regulator_target_code <= linear_regulator_voltage_code_reg[5:0];
            first_buck_current_limit <=
                current_limit_cfg_low_reg[`RVC_F_ILIM1_HI:`RVC_F_ILIM1_LO];
            second_buck_current_limit <=
                current_limit_cfg_low_reg[`RVC_F_ILIM2_HI:`RVC_F_ILIM2_LO];
            third_buck_current_limit <=
                current_limit_cfg_low_reg[`RVC_F_ILIM3_HI:`RVC_F_ILIM3_LO];
            first_buck_overcurrent_trip_en <= ~trip_dis[0];
            second_buck_overcurrent_trip_en <= ~trip_dis[1];
            // Codes past the top of the active range are flagged, not clipped
            vcode_over_range[0] <= third_buck_feedback_scale ?
                (rail3_voltage_code_reg > `RVC_BUCK_HALF_MAX) :
                (rail3_voltage_code_reg > `RVC_BUCK_FULL_MAX);
            vcode_over_range[1] <= fourth_buck_feedback_scale ?
                (rail4_voltage_code_reg > `RVC_BUCK_HALF_MAX) :
                (rail4_voltage_code_reg > `RVC_BUCK_FULL_MAX);
            vcode_over_range[2] <= fifth_buck_feedback_scale ?
                (rail5_voltage_code_reg > `RVC_BUCK_HALF_MAX) :
                (rail5_voltage_code_reg > `RVC_BUCK_FULL_MAX);
        end
    end

    // Switching-cycle and overcurrent inputs come from the analog side: three stages each
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
            oc_sync1_reg <= 3'h0;
            oc_sync2_reg <= 3'h0;
            oc_sync3_reg <= 3'h0;
            cyc_state_reg <= 3'h0;
            oc_state_reg <= 3'h0;
        end else begin
            sync1_reg <= sw_cycle;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            oc_sync1_reg <= oc_detect;
            oc_sync2_reg <= oc_sync1_reg;
            oc_sync3_reg <= oc_sync2_reg;
            for (i = 0; i < 3; i = i + 1) begin
                if (cyc_change[i]) begin
                    cyc_state_reg[i] <= sync3_reg[i];
                end
                if (oc_sync2_reg[i] == oc_sync3_reg[i]) begin
                    oc_state_reg[i] <= oc_sync3_reg[i];
                end
            end
        end
    end

    // Only rails 1 and 2 carry a trip control here; rail3 detect is synchronised but unused
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg[0] <= 5'h00;
            cnt_reg[1] <= 5'h00;
            oc_fault <= 2'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                // Disable outranks counting, so a disabled rail never raises a fault
                if (trip_dis[i]) begin
                    cnt_reg[i] <= 5'h00;
                    oc_fault[i] <= 1'b0;
                end else if (cyc_rise[i]) begin
                    if (!oc_state_reg[i]) begin
                        cnt_reg[i] <= 5'h00;
                    end else if (cnt_reg[i] != TRIP_FULL) begin
                        // Count saturates at the trip level; the fault outlives the count
                        cnt_reg[i] <= cnt_reg[i] + 5'h01;
                        if (cnt_reg[i] == TRIP_LAST) begin
                            oc_fault[i] <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule // rvc_cfg_regs

//--- inc/rvc_map.vh
// Register map and field layout of the rail voltage and current configuration bank
`ifndef RVC_MAP_VH
`define RVC_MAP_VH
`define RVC_ADDR_RAIL3_VCODE 8'h58
`define RVC_ADDR_RAIL4_VCODE 8'h59
`define RVC_ADDR_RAIL5_VCODE 8'h5a
`define RVC_ADDR_LDO_VCODE 8'h5b
`define RVC_ADDR_OC_CFG_LOW 8'h5c
`define RVC_RST_VCODE 8'h00
`define RVC_RST_LDO_VCODE 8'h06
`define RVC_RST_OC_CFG 8'h00
`define RVC_LDO_CODE_MASK 8'h3f
`define RVC_BUCK_FULL_MAX 8'hb4
`define RVC_BUCK_HALF_MAX 8'h9e
`define RVC_LDO_MIN 6'h06
`define RVC_LDO_MAX 6'h2f
`define RVC_F_ILIM1_HI 7
`define RVC_F_ILIM1_LO 6
`define RVC_F_TRIP1_DIS 5
`define RVC_F_ILIM2_HI 4
`define RVC_F_ILIM2_LO 3
`define RVC_F_TRIP2_DIS 2
`define RVC_F_ILIM3_HI 1
`define RVC_F_ILIM3_LO 0
`define RVC_OC_TRIP_CYCLES 5'h10
`endif

//--- verification/rvc_cfg_props.sv
// Port checks for the rail configuration register bank
`timescale 1ns/1ns
module rvc_cfg_props (
    input wire sys_clk,
    input wire arst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire reg_addr_err,
    input wire [1:0] first_buck_current_limit,
    input wire first_buck_overcurrent_trip_en,
    input wire [1:0] oc_fault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire wr5c = reg_wr && reg_addr == 8'h5c;
    wire [1:0] wd_lim = reg_wdata[7:6];
    wire wd_dis = reg_wdata[5];
    chk_read_answered: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("stray read valid");
    chk_unmapped_err: assert property ((reg_wr || reg_rd) &&
        (reg_addr < 8'h58 || reg_addr > 8'h5c) |=> reg_addr_err) else $error("no address error");
    chk_ldo_rsvd_zero: assert property (reg_rd && reg_addr == 8'h5b |=>
        reg_rdata[7:6] == 2'b00) else $error("reserved ldo bits read back");
    chk_ilim_field: assert property (wr5c |=> ##1
        first_buck_current_limit == $past(wd_lim, 2)) else $error("limit field wrong");
    chk_trip_en_inv: assert property (wr5c |=> ##1
        first_buck_overcurrent_trip_en == !$past(wd_dis, 2)) else $error("trip enable wrong");
    chk_fault_gated: assert property ($rose(oc_fault[0]) |->
        first_buck_overcurrent_trip_en) else $error("fault while disabled");
    chk_fault_sticky: assert property (oc_fault[0] && first_buck_overcurrent_trip_en &&
        !reg_wr && !$past(reg_wr) |=> oc_fault[0]) else $error("fault dropped");
    cover property (wr5c);
    cover property ($rose(oc_fault[0]));
    cover property (reg_addr_err);
endmodule // rvc_cfg_props
bind rvc_cfg_regs rvc_cfg_props u_props (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_addr_err(reg_addr_err), .oc_fault(oc_fault),
    .first_buck_current_limit(first_buck_current_limit),
    .first_buck_overcurrent_trip_en(first_buck_overcurrent_trip_en));

//--- verification/rvc_stage_model.sv
// Power stage stand-in: switching cycles with overcurrent levels
`timescale 1ns/1ns
module rvc_stage_model (
    input wire sys_clk,
    input wire arst_n,
    input wire run,
    input wire [2:0] oc_lvl,
    output wire [2:0] sw_cycle,
    output reg [2:0] oc_detect
);
    reg [3:0] ph_reg;
    assign sw_cycle = {3{run & ph_reg[3]}};
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_reg <= 4'h0;
            oc_detect <= 3'h0;
        end else begin
            ph_reg <= ph_reg + 4'h1;
            // Level moves far from the switch edge so it is settled across it
            if (ph_reg == 4'h2) oc_detect <= oc_lvl;
        end
    end
endmodule // rvc_stage_model

//--- verification/tb_rvc_cfg_regs.sv
// Self-checking bench for the rail configuration register bank
`timescale 1ns/1ns
module tb_rvc_cfg_regs;
    reg sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg [2:0] fbs = 3'h0, oc_lvl = 3'h0;
    wire [2:0] sw, ocd, over;
    wire [7:0] rdata, t3, t4, t5;
    wire rvalid, aerr, en1, en2;
    wire [5:0] ldo;
    wire [1:0] l1, l2, l3, fault;
    integer err_total = 0, n_compared = 0, i;
    always #5 sys_clk = ~sys_clk;
    rvc_cfg_regs dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .third_buck_feedback_scale(fbs[0]),
        .fourth_buck_feedback_scale(fbs[1]), .fifth_buck_feedback_scale(fbs[2]),
        .sw_cycle(sw), .oc_detect(ocd), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .reg_addr_err(aerr), .third_buck_target_code(t3), .fourth_buck_target_code(t4),
        .fifth_buck_target_code(t5), .linear_regulator_target_code(ldo),
        .first_buck_current_limit(l1), .second_buck_current_limit(l2),
        .third_buck_current_limit(l3), .first_buck_overcurrent_trip_en(en1),
        .second_buck_overcurrent_trip_en(en2), .oc_fault(fault), .vcode_over_range(over));
    rvc_stage_model u_stage (.sys_clk(sys_clk), .arst_n(arst_n), .run(run), .oc_lvl(oc_lvl),
        .sw_cycle(sw), .oc_detect(ocd));
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            // Idle cycle keeps a strobe from being assigned twice at one edge
            @(posedge sys_clk);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e, input ae);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            @(negedge sys_clk);
            cmp({7'h0, rvalid}, 8'h01);
            cmp({7'h0, aerr}, {7'h0, ae});
            cmp(rdata, e);
            @(posedge sys_clk);
        end
    endtask
    task final_report;
        begin
            $display("compared=%0d errors=%0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #50000;
        err_total = err_total + 1;
        final_report;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 5; i = i + 1) rd(8'h58 + i[7:0], i == 3 ? 8'h06 : 8'h00, 1'b0);
        wr(8'h58, 8'hb4);
        wr(8'h59, 8'h9e);
        wr(8'h5a, 8'h01);
        wr(8'h5b, 8'hff);
        wr(8'h5c, 8'h5b);
        wr(8'h5d, 8'hff);
        rd(8'h5b, 8'h3f, 1'b0);
        rd(8'h5d, 8'h00, 1'b1);
        rd(8'h57, 8'h00, 1'b1);
        @(negedge sys_clk);
        cmp(t3, 8'hb4);
        cmp(t4, 8'h9e);
        cmp(t5, 8'h01);
        cmp({l1, en1, l2, en2, l3}, 8'h7f);
        cmp({5'h0, over}, 8'h00);
        @(posedge sys_clk);
        fbs <= 3'h7;
        wr(8'h5b, 8'h2f);
        repeat (3) @(negedge sys_clk);
        cmp({5'h0, over}, 8'h01);
        cmp({2'h0, ldo}, 8'h2f);
        @(posedge sys_clk);
        wr(8'h5c, 8'h00);
        run <= 1'b1;
        for (i = 0; i < 33; i = i + 1) begin
            oc_lvl <= {1'b1, i != 15 && i < 31, i < 20};
            repeat (16) @(posedge sys_clk);
        end
        cmp({6'h0, fault}, 8'h01);
        wr(8'h5c, 8'h20);
        repeat (4) @(negedge sys_clk);
        cmp({6'h0, fault}, 8'h00);
        final_report;
    end
endmodule // tb_rvc_cfg_regs
